// ### eoh_tx_overhead_port.sv
// Purpose: overhead insert port of an e3 transmit framer, device-clocked method
// Assumes: framer gives frame start and parity enable on sys_clk
// Notes: overhead clock is divided from sys_clk, so its edges are known internally
`timescale 1ns/10ps
`default_nettype none
module eoh_tx_overhead_port #(
  parameter int unsigned FIFO_DEPTH = eoh_pkg::FIFO_DEPTH
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic frameStart,
  input  wire logic parityEnable,
  input  wire logic alarmInternal,
  input  wire logic nationalInternal,
  input  wire logic frameLatch,
  input  wire logic overhead_serial_in,
  input  wire logic overhead_insert_enable,
  output logic      overhead_clock_out,
  output logic      overhead_frame_marker,
  output logic      alarmOut,
  output logic      nationalOut
);
  logic       rstMeta_n;
  logic       rstSync_n;
  logic [1:0] dataSync;
  logic [1:0] insSync;
  logic [7:0] divCount;
  logic [4:0] bitPos;
  logic       busy;
  logic       startPending;
  logic       alarmHeld;
  logic       nationalHeld;
  logic       alarmFlag;
  logic       nationalFlag;
  eoh_pkg::eoh_ins_t fifoIn;
  eoh_pkg::eoh_ins_t fifoOut;
  logic       fifoInReady;
  logic       fifoOutValid;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // pin inputs pass two flops before use
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      dataSync <= '0;
      insSync  <= '0;
    end
    else
    begin
      dataSync <= {dataSync[0], overhead_serial_in};
      insSync  <= {insSync[0], overhead_insert_enable};
    end
  end

  // overhead clock edges come from the divider, so no edge detection is needed
  wire divWrap    = (divCount == 8'(eoh_pkg::HALF_DIV - 1));
  wire riseNext   = divWrap && !overhead_clock_out;
  wire fallNext   = divWrap && overhead_clock_out;
  wire lastPos    = parityEnable ? (bitPos == eoh_pkg::POS_PAR_LAST)
                                 : (bitPos == eoh_pkg::POS_NAT_LAST);
  wire posAlarm   = busy && (bitPos == eoh_pkg::POS_ALARM);
  wire posNat     = busy && (bitPos == eoh_pkg::POS_NATIONAL);
  // sampling gated by insert level and insertable position only
  wire takeBit    = fallNext && insSync[1] && (posAlarm || posNat);
  assign fifoIn   = '{national: posNat, value: dataSync[1]};

  // clock divider drives the overhead clock output
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      divCount           <= '0;
      overhead_clock_out <= 1'b0;
    end
    else
    begin
      divCount           <= divWrap ? '0 : 8'(divCount + 1'b1);
      if (divWrap)
        overhead_clock_out <= !overhead_clock_out;
    end
  end

  // position sequencer; marker stands over the count-zero rising edge
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      startPending          <= 1'b0;
      busy                  <= 1'b0;
      bitPos                <= '0;
      overhead_frame_marker <= 1'b0;
    end
    else
    begin
      if (frameStart)
        startPending <= 1'b1;
      if (fallNext && startPending && !busy)
      begin
        overhead_frame_marker <= 1'b1;
        startPending          <= frameStart;
      end
      else if (fallNext)
        overhead_frame_marker <= 1'b0;
      if (riseNext && overhead_frame_marker)
      begin
        busy   <= 1'b1;
        bitPos <= eoh_pkg::POS_ZERO;
      end
      else if (riseNext && busy)
      begin
        if (lastPos)
          busy <= 1'b0;
        else
          bitPos <= 5'(bitPos + 1'b1);
      end
    end
  end

  eoh_fifo #(
    .WIDTH ($bits(eoh_pkg::eoh_ins_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .inValid   (takeBit),
    .inReady   (fifoInReady),
    .inData    (fifoIn),
    .outValid  (fifoOutValid),
    .outReady  (1'b1),
    .outData   (fifoOut)
  );

  // hold accepted values until the next frame latches them; full fifo drops the bit
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      alarmHeld    <= 1'b0;
      nationalHeld <= 1'b0;
      alarmFlag    <= 1'b0;
      nationalFlag <= 1'b0;
      alarmOut     <= 1'b0;
      nationalOut  <= 1'b0;
    end
    else
    begin
      if (frameLatch)
      begin
        alarmOut    <= alarmFlag ? alarmHeld : alarmInternal;
        nationalOut <= nationalFlag ? nationalHeld : nationalInternal;
      end
      // new value wins over the per-frame clear
      if (fifoOutValid && !fifoOut.national)
      begin
        alarmHeld <= fifoOut.value;
        alarmFlag <= 1'b1;
      end
      else if (frameLatch)
        alarmFlag <= 1'b0;
      if (fifoOutValid && fifoOut.national)
      begin
        nationalHeld <= fifoOut.value;
        nationalFlag <= 1'b1;
      end
      else if (frameLatch)
        nationalFlag <= 1'b0;
    end
  end

  wire unusedReady = fifoInReady;
endmodule : eoh_tx_overhead_port
`default_nettype wire

// ### eoh_pkg.sv
// Purpose: shared constants and types for the e3 overhead insert port
// Assumes: sys_clk at 50 MHz
// Notes: overhead bit positions counted from the frame marker edge
`default_nettype none
package eoh_pkg;
  localparam int unsigned SYS_CLK_HZ     = 50_000_000;
  localparam int unsigned OH_CLK_HZ      = 6_250_000;
  localparam int unsigned HALF_DIV       = SYS_CLK_HZ / OH_CLK_HZ / 2;
  localparam int unsigned FAW_BITS       = 10;
  localparam logic [4:0]  POS_ALARM      = 5'h0a;
  localparam logic [4:0]  POS_NATIONAL   = 5'h0b;
  localparam logic [4:0]  POS_PAR_LAST   = 5'h0f;
  localparam logic [4:0]  POS_NAT_LAST   = 5'h0b;
  localparam logic [4:0]  POS_ZERO       = 5'h00;
  localparam int unsigned FIFO_DEPTH     = 8;

  // one accepted insertion: which bit and its value
  typedef struct packed {
    logic       national;
    logic       value;
  } eoh_ins_t;
endpackage : eoh_pkg
`default_nettype wire

// ### eoh_fifo.sv
// Purpose: small valid/ready fifo for accepted overhead insertions
// Assumes: single clock
// Notes: full and empty are exact; drain side may stall
`timescale 1ns/10ps
`default_nettype none
module eoh_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstSync_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = mem[rdPtr];

  // storage written only when accepted
  always_ff @(posedge sys_clk)
  begin
    if (doWrite)
      mem[wrPtr] <= inData;
  end

  // pointers and fill level
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : AW'(wrPtr + 1'b1);
      if (doRead)
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : AW'(rdPtr + 1'b1);
      fill <= (AW+1)'(fill + (doWrite ? 1 : 0) - (doRead ? 1 : 0));
    end
  end
endmodule : eoh_fifo
`default_nettype wire

// ### eoh_port_asserts.sv
// Purpose: port checks of the overhead insert port
// Assumes: one sys_clk domain, rst_n async
// Notes: counts follow the divide-by-8 overhead clock
`timescale 1ns/10ps
`default_nettype none
module eoh_port_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic frameStart,
  input wire logic frameLatch,
  input wire logic overhead_clock_out,
  input wire logic overhead_frame_marker,
  input wire logic alarmOut,
  input wire logic nationalOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // short aliases keep properties readable
  wire ck = overhead_clock_out;
  wire mk = overhead_frame_marker;
  sequence s_hi4;
    ck [*4];
  endsequence
  a_clk_high: assert property ($rose(ck) |-> s_hi4 ##1 !ck)
    else $error("oh clock high time");
  a_clk_low: assert property ($fell(ck) |-> !ck [*4] ##1 ck)
    else $error("oh clock low time");
  a_clk_period: assert property ($rose(ck) |-> ##8 $rose(ck))
    else $error("oh clock period");
  a_marker_width: assert property ($rose(mk) |-> mk [*8] ##1 !mk)
    else $error("marker width");
  a_marker_start: assert property (frameStart |-> ##[1:10] $rose(mk))
    else $error("no marker");
  a_marker_phase: assert property ($rose(mk) |-> !ck ##[1:4] $rose(ck))
    else $error("marker phase");
  // outputs move only in the cycle after a latch pulse
  a_alarm_hold: assert property ($changed(alarmOut) |-> $past(frameLatch))
    else $error("alarm moved");
  a_national_hold: assert property ($changed(nationalOut) |-> $past(frameLatch))
    else $error("national moved");
endmodule : eoh_port_asserts
bind eoh_tx_overhead_port eoh_port_asserts eoh_port_asserts_i (.sys_clk, .rst_n, .frameStart, .frameLatch,
  .overhead_clock_out, .overhead_frame_marker, .alarmOut, .nationalOut);
`default_nettype wire

// ### eoh_term_model.sv
// Purpose: terminal equipment that inserts overhead bits
// Assumes: positions count from the rise that sees the marker
// Notes: data toggles when idle so a stale bit never looks valid
`timescale 1ns/10ps
`default_nettype none
module eoh_term_model (
  input  wire logic        overhead_clock_out,
  input  wire logic        overhead_frame_marker,
  input  wire logic [15:0] insMask,
  input  wire logic [15:0] insBits,
  output var logic         overhead_insert_enable,
  output var logic         overhead_serial_in,
  output var int           frames
);
  int pos = 99;
  initial
  begin
    overhead_insert_enable = 1'b0;
    overhead_serial_in     = 1'b0;
    frames                 = 0;
  end
  // launch on the rise, hold one full period
  always @(posedge overhead_clock_out)
  begin
    pos    = overhead_frame_marker ? 0 : pos + 1;
    frames = frames + (overhead_frame_marker ? 1 : 0);
    overhead_insert_enable <= pos < 16 && insMask[pos];
    overhead_serial_in     <= (pos < 16 && insMask[pos]) ? insBits[pos] : ~overhead_serial_in;
  end
endmodule : eoh_term_model
`default_nettype wire

// ### eoh_tx_overhead_port_tb.sv
// Purpose: self-checking bench of the overhead insert port
// Assumes: terminal model paces inserts on the overhead clock
// Notes: own values oppose inserted ones so a lost insert shows
`timescale 1ns/10ps
`default_nettype none
module eoh_tx_overhead_port_tb;
  logic        sys_clk, rst_n, frameStart, parityEnable, alarmInternal, nationalInternal, frameLatch;
  logic        overhead_serial_in, overhead_insert_enable, overhead_clock_out, overhead_frame_marker;
  logic        alarmOut, nationalOut;
  logic [15:0] insMask, insBits;
  logic [31:0] seed;
  int          frames, n_mismatch, num_checks;
  eoh_tx_overhead_port eoh_tx_overhead_port_i (.sys_clk, .rst_n, .frameStart, .parityEnable, .alarmInternal,
    .nationalInternal, .frameLatch, .overhead_serial_in, .overhead_insert_enable, .overhead_clock_out,
    .overhead_frame_marker, .alarmOut, .nationalOut);
  eoh_term_model eoh_term_model_i (.overhead_clock_out, .overhead_frame_marker, .insMask, .insBits,
    .overhead_insert_enable, .overhead_serial_in, .frames);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // inserted value wins over the framer's own
  function automatic logic expect_bit(input int p, input logic own);
    return insMask[p] ? insBits[p] : own;
  endfunction : expect_bit
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check_bit
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // frames 0..2: every position, none, refused neighbours only
  initial
  begin
    int seen;
    {rst_n, frameStart, parityEnable, alarmInternal, nationalInternal, frameLatch} = 6'h00;
    {insMask, insBits} = 32'h0000_0000;
    seed = 32'h9852_471d;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int f = 0; f < 24; f++)
    begin
      seed = lfsr_next(seed);
      insMask <= (f == 0) ? 16'hffff : (f == 1) ? 16'h0000 : (f == 2) ? 16'h1200 : seed[15:0];
      insBits <= seed[31:16];
      {alarmInternal, nationalInternal, parityEnable} <= {~seed[26], ~seed[27], seed[3]};
      @(posedge sys_clk);
      frameStart <= 1'b1;
      @(posedge sys_clk);
      frameStart <= 1'b0;
      seen = frames;
      for (int t = 0; t < 40 && frames == seen; t++)
        @(posedge sys_clk);
      if (frames == seen)
      begin
        n_mismatch++;
        close_out();
      end
      // sixteen positions plus sync and fifo latency
      repeat (150) @(posedge sys_clk);
      frameLatch <= 1'b1;
      @(posedge sys_clk);
      frameLatch <= 1'b0;
      @(posedge sys_clk);
      check_bit(alarmOut, expect_bit(10, alarmInternal));
      check_bit(nationalOut, expect_bit(11, nationalInternal));
    end
    close_out();
  end
endmodule : eoh_tx_overhead_port_tb
`default_nettype wire
